// ==== rfia_defs.svh ====
// Constants of the radio interrupt aggregator
// Overview of operation
// - Two vectors: error on 0, events on 12
// - Error vector only for underflow or overflow
// - Main enable bits gate each vector
// - Pending requests kept in main flag bits
// - Event sources set flags on rising edges
// - Eight sources, own flag and mask bit
// - Masked source still sets its flag
// - Event request needs mask and main enable
// - Leftover flag requests the vector again
// - Bit 7 set on regulator turned on
// - Bit 6 set on transmit or reported ack
// - Bit 5 set on fill above threshold
// - Bit 4 set on frame delimiter found
// - Bit 3 set when channel is clear
// - Bits 2..0 from strobe processor events
// - Flag reads show status regardless of mask
// - Overflow raises error request, data untouched
`ifndef RFIA_DEFS_SVH
`define RFIA_DEFS_SVH

// Register offsets on the special function bus
`define RFIA_OFS_FLAGS     8'hE9
`define RFIA_OFS_MASK      8'h91
`define RFIA_OFS_IEN_A     8'hA8
`define RFIA_OFS_IEN_C     8'h9A
`define RFIA_OFS_TIMER_CTL 8'h88
`define RFIA_OFS_SER_CTL1  8'h9B

// Field positions inside shared control registers
`define RFIA_BIT_ERR_EN    0
`define RFIA_BIT_EVT_EN    0
`define RFIA_BIT_ERR_FLAG  0
`define RFIA_BIT_EVT_FLAG  0

// Reset values
`define RFIA_RST_FLAGS     8'h00
`define RFIA_RST_MASK      8'h00

// Processor vector numbers
`define RFIA_VEC_ERR       0
`define RFIA_VEC_EVT       12
`define RFIA_VEC_COUNT     13

// Read answer latency in cycles
`define RFIA_RD_LAT        1

`endif

// ==== rfia_pkg.sv ====
// Types shared by the radio interrupt aggregator
package rfia_pkg;

  // Eight event source conditions, bit 7 first
  typedef struct packed {
    logic regulator_on;
    logic tx_complete;
    logic rx_threshold;
    logic frame_delimiter;
    logic channel_clear;
    logic strobe_proc_wait;
    logic strobe_proc_halt;
    logic strobe_proc_int;
  } rfia_src_s;

  // Error conditions feeding the error vector
  typedef struct packed {
    logic tx_underflow;
    logic rx_overflow;
  } rfia_err_src_s;

  // One access on the special function bus
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } rfia_sfr_req_s;

  // Software state held in the top module
  typedef struct packed {
    logic [7:0] mask;
    logic       err_en;
    logic       evt_en;
    logic [7:0] rdata;
    logic       rvalid;
  } rfia_regs_s;

endpackage

// ==== rfia_edge_det.sv ====
// Rising edge detector for a group of level conditions
`timescale 1ns/100ps
module rfia_edge_det #(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise
);

  // Previous level of each condition
  typedef struct packed {
    logic [W-1:0] prev;
  } rfia_edge_s;

  rfia_edge_s cur_ff;
  rfia_edge_s nxt_cur;

  // Only a 0 to 1 change counts; a held level is quiet
  assign rise = level_in & ~cur_ff.prev;

  // Next state
  always_comb begin
    nxt_cur      = cur_ff;
    nxt_cur.prev = level_in;
  end

  // Cleared history, so a level high at release fires once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

endmodule

// ==== rfia_flag_bank.sv ====
// Sticky flag bits, hardware set and software clear
`timescale 1ns/100ps
module rfia_flag_bank #(
  parameter int         W      = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output logic      [W-1:0] flags
);

  // Flag storage
  typedef struct packed {
    logic [W-1:0] q;
  } rfia_bank_s;

  rfia_bank_s cur_ff;
  rfia_bank_s nxt_cur;

  assign flags = cur_ff.q;

  // Set beats clear, so an event in the clearing cycle survives
  always_comb begin
    nxt_cur   = cur_ff;
    nxt_cur.q = (cur_ff.q & ~clr_in) | set_in;
  end

  // Register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff.q <= RST_VAL;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

endmodule

// ==== rfia_top.sv ====
// Radio interrupt aggregator: flags, masks and vector requests
`timescale 1ns/100ps
`include "rfia_defs.svh"
module rfia_top #(
  parameter int CW = 8
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire rfia_pkg::rfia_sfr_req_s sfr_req,
  output logic [7:0]                  sfr_rdata,
  output logic                        sfr_rvalid,
  input  wire rfia_pkg::rfia_src_s    src_level,
  input  wire logic                   ack_frame_done,
  input  wire logic                   ack_report_option,
  input  wire logic [CW-1:0]          rx_fill_count,
  input  wire logic [CW-1:0]          rx_fill_threshold,
  input  wire rfia_pkg::rfia_err_src_s err_level,
  output logic [`RFIA_VEC_COUNT-1:0]  irq_lines,
  output logic                        radio_error_request,
  output logic                        radio_event_request
);

  // Address match, used by every register access
  function automatic logic sfr_hit(input logic [7:0] a,
                                   input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Write of a zero to one bit clears it; ones leave it alone
  function automatic logic [7:0] zero_clear(input logic hit,
                                            input logic [7:0] d);
    return hit ? ~d : 8'h00;
  endfunction

  // Software state
  rfia_pkg::rfia_regs_s cur_ff;
  rfia_pkg::rfia_regs_s nxt_cur;

  // Conditions after option and threshold handling
  rfia_pkg::rfia_src_s  cond;
  logic [9:0]           all_rise;    // Event and error edges
  logic [7:0]           evt_rise;    // Event source edges
  logic [1:0]           err_rise;    // Error source edges
  logic [7:0]           evt_flags;   // Per source flags
  logic [7:0]           evt_clr;     // Software clears of flags
  logic [1:0]           main_flags;  // Error and event main flags
  logic [1:0]           main_set;    // Hardware set of main flags
  logic [1:0]           main_clr;    // Software clear of main flags
  logic                 evt_any;     // Unmasked pending source
  logic                 wr_flags;    // Write to flag register
  logic                 wr_tctl;     // Write to timer control
  logic                 wr_sctl;     // Write to serial control 1

  // Build the eight source conditions
  always_comb begin
    cond = src_level;
    // Acks count as done only with reporting on
    cond.tx_complete = src_level.tx_complete |
                       (ack_frame_done & ack_report_option);
    // Strictly above threshold, not equal
    cond.rx_threshold = rx_fill_count > rx_fill_threshold;
  end

  // One detector for all ten conditions keeps history aligned
  rfia_edge_det #(
    .W (10)
  ) u_edges (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .level_in ({cond, err_level}),
    .rise     (all_rise)
  );

  assign evt_rise = all_rise[9:2];
  assign err_rise = all_rise[1:0];

  // Write decode
  assign wr_flags = sfr_req.wr & sfr_hit(sfr_req.addr, `RFIA_OFS_FLAGS);
  assign wr_tctl  = sfr_req.wr &
                    sfr_hit(sfr_req.addr, `RFIA_OFS_TIMER_CTL);
  assign wr_sctl  = sfr_req.wr &
                    sfr_hit(sfr_req.addr, `RFIA_OFS_SER_CTL1);

  // Software clears flags by writing zeros
  assign evt_clr = zero_clear(wr_flags, sfr_req.wdata);

  // Per source flags; the mask plays no part in setting them
  rfia_flag_bank #(
    .W       (8),
    .RST_VAL (`RFIA_RST_FLAGS)
  ) u_evt_flags (
    .ref_clk (ref_clk),
    .rst     (rst),
    .set_in  (evt_rise),
    .clr_in  (evt_clr),
    .flags   (evt_flags)
  );

  // Any flag that survives its mask keeps asking
  assign evt_any = |(evt_flags & cur_ff.mask);

  // Main flags: bit 1 event, bit 0 error
  always_comb begin
    main_set    = 2'b00;
    main_clr    = 2'b00;
    // Only underflow and overflow reach the error flag
    main_set[0] = |err_rise;
    // Held set while a flag stays pending, so it re-asks
    main_set[1] = evt_any;
    main_clr[0] = wr_tctl & ~sfr_req.wdata[`RFIA_BIT_ERR_FLAG];
    main_clr[1] = wr_sctl & ~sfr_req.wdata[`RFIA_BIT_EVT_FLAG];
  end

  // Main pending flags
  rfia_flag_bank #(
    .W       (2),
    .RST_VAL (2'h0)
  ) u_main_flags (
    .ref_clk (ref_clk),
    .rst     (rst),
    .set_in  (main_set),
    .clr_in  (main_clr),
    .flags   (main_flags)
  );

  // Requests: second masking layer is the main enable
  assign radio_error_request = main_flags[0] & cur_ff.err_en;
  assign radio_event_request = main_flags[1] & cur_ff.evt_en;

  // Only the two radio vectors are driven
  always_comb begin
    irq_lines                 = '0;
    irq_lines[`RFIA_VEC_ERR]  = radio_error_request;
    irq_lines[`RFIA_VEC_EVT]  = radio_event_request;
  end

  // Register writes and registered read data
  always_comb begin
    nxt_cur        = cur_ff;
    nxt_cur.rvalid = sfr_req.rd;
    // Mask and main enables
    if (sfr_req.wr) begin
      if (sfr_hit(sfr_req.addr, `RFIA_OFS_MASK)) begin
        nxt_cur.mask = sfr_req.wdata;
      end
      if (sfr_hit(sfr_req.addr, `RFIA_OFS_IEN_A)) begin
        nxt_cur.err_en = sfr_req.wdata[`RFIA_BIT_ERR_EN];
      end
      if (sfr_hit(sfr_req.addr, `RFIA_OFS_IEN_C)) begin
        nxt_cur.evt_en = sfr_req.wdata[`RFIA_BIT_EVT_EN];
      end
    end
    // Read mux; unmapped and foreign bits read as zero
    if (sfr_req.rd) begin
      nxt_cur.rdata = 8'h00;
      if (sfr_hit(sfr_req.addr, `RFIA_OFS_FLAGS)) begin
        nxt_cur.rdata = evt_flags;
      end else if (sfr_hit(sfr_req.addr, `RFIA_OFS_MASK)) begin
        nxt_cur.rdata = cur_ff.mask;
      end else if (sfr_hit(sfr_req.addr, `RFIA_OFS_IEN_A)) begin
        nxt_cur.rdata[`RFIA_BIT_ERR_EN] = cur_ff.err_en;
      end else if (sfr_hit(sfr_req.addr, `RFIA_OFS_IEN_C)) begin
        nxt_cur.rdata[`RFIA_BIT_EVT_EN] = cur_ff.evt_en;
      end else if (sfr_hit(sfr_req.addr, `RFIA_OFS_TIMER_CTL)) begin
        nxt_cur.rdata[`RFIA_BIT_ERR_FLAG] = main_flags[0];
      end else if (sfr_hit(sfr_req.addr, `RFIA_OFS_SER_CTL1)) begin
        nxt_cur.rdata[`RFIA_BIT_EVT_FLAG] = main_flags[1];
      end
    end
  end

  // State register; everything disabled and clear at reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur_ff      <= '0;
      cur_ff.mask <= `RFIA_RST_MASK;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Read data stays until the next read
  assign sfr_rdata  = cur_ff.rdata;
  assign sfr_rvalid = cur_ff.rvalid;

  // Checks on the design's own outputs and internal state
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Vector lines carry only the two requests
  property p_vec_map;
    (irq_lines[`RFIA_VEC_ERR] == radio_error_request) &&
    (irq_lines[`RFIA_VEC_EVT] == radio_event_request) &&
    ($countones(irq_lines) <=
     (int'(radio_error_request) + int'(radio_event_request)));
  endproperty
  a_vec_map: assert property (p_vec_map)
    else $error("vector lines do not match requests");

  // Error flag rises only after an error edge
  property p_err_cause;
    $rose(main_flags[0]) |-> $past(|err_level) || $past(|err_rise);
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("error flag set without an error event");

  // Overflow edge with enable on gives request next cycle
  property p_ovf_req;
    (err_rise[0] && cur_ff.err_en && !wr_tctl &&
     !(sfr_req.wr && sfr_hit(sfr_req.addr, `RFIA_OFS_IEN_A)))
      |=> radio_error_request;
  endproperty
  a_ovf_req: assert property (p_ovf_req)
    else $error("overflow did not raise error request");

  // Error request needs enable and pending flag
  property p_err_gate;
    radio_error_request |-> cur_ff.err_en && main_flags[0];
  endproperty
  a_err_gate: assert property (p_err_gate)
    else $error("error request without enable or flag");

  // Event request needs both masking layers
  property p_evt_gate;
    radio_event_request |-> cur_ff.evt_en && main_flags[1];
  endproperty
  a_evt_gate: assert property (p_evt_gate)
    else $error("event request without enable or flag");

  // A flag only appears after a rising edge of its source
  property p_edge_only;
    ((evt_flags & ~$past(evt_flags)) & ~$past(evt_rise)) == 8'h00;
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("flag set without a source edge");

  // An edge sets its flag whatever the mask says
  property p_mask_free;
    (|evt_rise) |=> ((evt_flags & $past(evt_rise)) == $past(evt_rise));
  endproperty
  a_mask_free: assert property (p_mask_free)
    else $error("source edge lost its flag");

  // Unmasked pending flag keeps the main event flag up
  property p_rerequest;
    evt_any |=> main_flags[1];
  endproperty
  a_rerequest: assert property (p_rerequest)
    else $error("pending flag did not re-request");

  // Fill count crossing threshold sets bit 5
  property p_fill;
    $rose(rx_fill_count > rx_fill_threshold) |=> evt_flags[5];
  endproperty
  a_fill: assert property (p_fill)
    else $error("threshold crossing missed");

  // Reported ack edge sets bit 6
  property p_ack;
    $rose(ack_frame_done && ack_report_option) && !$past(cond.tx_complete)
      |=> evt_flags[6];
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge completion missed");

  // Flag register read returns flags, mask ignored
  property p_read_flags;
    (sfr_req.rd && sfr_hit(sfr_req.addr, `RFIA_OFS_FLAGS))
      |=> sfr_rvalid && (sfr_rdata == $past(evt_flags));
  endproperty
  a_read_flags: assert property (p_read_flags)
    else $error("flag read returned wrong value");

  // An error edge sets its main flag even during a clear
  property p_err_set;
    (|err_rise) |=> main_flags[0];
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("error edge did not set the error flag");

  // Error edges never reach the event vector
  property p_err_not_evt;
    ((|err_rise) && !evt_any) |=> !$rose(main_flags[1]);
  endproperty
  a_err_not_evt: assert property (p_err_not_evt)
    else $error("error edge raised the event flag");

  // Event main flag rises only after an unmasked flag
  property p_evt_cause;
    $rose(main_flags[1]) |-> $past(evt_any);
  endproperty
  a_evt_cause: assert property (p_evt_cause)
    else $error("event flag set with nothing unmasked");

  // Unmasked edge with no writes asks two cycles later
  property p_evt_latency;
    (evt_rise[4] && cur_ff.mask[4] && cur_ff.evt_en && !sfr_req.wr)
      ##1 !sfr_req.wr |=> radio_event_request;
  endproperty
  a_evt_latency: assert property (p_evt_latency)
    else $error("event request late after delimiter edge");

  // A zero written to a quiet flag clears it
  property p_flag_clear;
    wr_flags |=> ((evt_flags & $past(evt_clr & ~evt_rise)) == 8'h00);
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("written zero did not clear a flag");

  // Every read is answered in the next cycle
  property p_rvalid_pulse;
    sfr_req.rd |=> sfr_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse)
    else $error("read not answered in the next cycle");

  // No answer strobe without a read before it
  property p_rvalid_cause;
    sfr_rvalid |-> $past(sfr_req.rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("read answer without a read");

  // Mask read returns the stored mask
  property p_mask_read;
    (sfr_req.rd && sfr_hit(sfr_req.addr, `RFIA_OFS_MASK))
      |=> (sfr_rdata == $past(cur_ff.mask));
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read returned wrong value");

  // Serial control read shows the event main flag in bit 0
  property p_main_read;
    (sfr_req.rd && sfr_hit(sfr_req.addr, `RFIA_OFS_SER_CTL1))
      |=> (sfr_rdata == {7'h00, $past(main_flags[1])});
  endproperty
  a_main_read: assert property (p_main_read)
    else $error("event main flag read wrong");

  // Main scenarios
  c_err_req: cover property (err_rise[1] ##1 radio_error_request);
  c_evt_req: cover property (evt_rise[4] ##2 radio_event_request);
  c_masked:  cover property ((|evt_rise) && !evt_any ##1 !evt_any);
  c_again:   cover property (radio_event_request && wr_sctl
                             ##1 radio_event_request);

endmodule

// ==== rfia_cpu_model.sv ====
// CPU interrupt controller model counting vector service entries
`timescale 1ns/100ps
`include "rfia_defs.svh"
module rfia_cpu_model (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic [`RFIA_VEC_COUNT-1:0] irq_lines,
  output logic      [7:0]                err_entries,
  output logic      [7:0]                evt_entries
);
  logic [1:0] seen_ff; // Last sampled level of both radio vectors

  // A line that rises is one new entry into its service routine;
  // a line held high is the same entry, as the controller latches it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen_ff     <= 2'h0;
      err_entries <= 8'h00;
      evt_entries <= 8'h00;
    end else begin
      seen_ff <= {irq_lines[`RFIA_VEC_EVT], irq_lines[`RFIA_VEC_ERR]};
      if (irq_lines[`RFIA_VEC_ERR] && !seen_ff[0]) begin
        err_entries <= err_entries + 8'h01;
      end
      if (irq_lines[`RFIA_VEC_EVT] && !seen_ff[1]) begin
        evt_entries <= evt_entries + 8'h01;
      end
    end
  end
endmodule

// ==== radio_interrupt_aggregator_tb.sv ====
// Self-checking bench for the radio interrupt aggregator
`timescale 1ns/100ps
`include "rfia_defs.svh"
module radio_interrupt_aggregator_tb;
  // One ordinary case: inputs and the flags they should leave
  typedef struct packed {
    logic [7:0] src;
    logic       ack;
    logic       opt;
    logic [7:0] cnt;
    logic [7:0] exp;
  } rfia_tb_row_s;

  logic                    ref_clk;             // System clock
  logic                    rst;                 // Synchronous reset
  rfia_pkg::rfia_sfr_req_s sfr_req;             // Register access
  logic [7:0]              sfr_rdata;           // Read answer
  logic                    sfr_rvalid;          // Read answer strobe
  rfia_pkg::rfia_src_s     src_level;           // Event conditions
  logic                    ack_frame_done;      // Ack frame sent
  logic                    ack_report_option;   // Ack counts as sent
  logic [7:0]              rx_fill_count;       // Receive fill level
  logic [7:0]              rx_fill_threshold;   // Fill threshold
  rfia_pkg::rfia_err_src_s err_level;           // Error conditions
  logic [12:0]             irq_lines;           // Vector lines
  logic                    radio_error_request; // Error vector
  logic                    radio_event_request; // Event vector
  logic [7:0]              err_entries;         // Error entries seen
  logic [7:0]              evt_entries;         // Event entries seen
  logic [7:0]              n_evt;               // Entries before a test
  int                      miscompares;         // Mismatches
  int                      checks_done;         // Comparisons
  rfia_tb_row_s            rows [11];           // Ordinary cases
  logic [7:0]              rst_addrs [7];       // Reset read list

  rfia_top i_rfia_top (
    .ref_clk             (ref_clk),
    .rst                 (rst),
    .sfr_req             (sfr_req),
    .sfr_rdata           (sfr_rdata),
    .sfr_rvalid          (sfr_rvalid),
    .src_level           (src_level),
    .ack_frame_done      (ack_frame_done),
    .ack_report_option   (ack_report_option),
    .rx_fill_count       (rx_fill_count),
    .rx_fill_threshold   (rx_fill_threshold),
    .err_level           (err_level),
    .irq_lines           (irq_lines),
    .radio_error_request (radio_error_request),
    .radio_event_request (radio_event_request)
  );

  rfia_cpu_model i_rfia_cpu_model (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .irq_lines   (irq_lines),
    .err_entries (err_entries),
    .evt_entries (evt_entries)
  );

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Compare and count; unknowns never match
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe, taken at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_req.addr  = a;
    sfr_req.wdata = d;
    sfr_req.wr    = 1'b1;
    @(negedge ref_clk);
    sfr_req.wr = 1'b0;
  endtask

  // One-cycle read strobe; answer strobe stands only in the next cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_req.addr = a;
    sfr_req.rd   = 1'b1;
    @(negedge ref_clk);
    sfr_req.rd = 1'b0;
    chk(sfr_rvalid, 1'b1);
    chk(sfr_rdata, exp);
  endtask

  // Raise conditions, then wait until the event request can show
  task automatic fire(input logic [7:0] s);
    @(negedge ref_clk);
    src_level = rfia_pkg::rfia_src_s'(s);
    repeat (2) @(negedge ref_clk);
  endtask

  // Drop every condition, then clear source flags before main flags,
  // since a main flag cleared first would be set again at once
  task automatic clear();
    @(negedge ref_clk);
    src_level      = rfia_pkg::rfia_src_s'(8'h00);
    err_level      = rfia_pkg::rfia_err_src_s'(2'h0);
    ack_frame_done = 1'b0;
    ack_report_option = 1'b0;
    rx_fill_count  = 8'h00;
    wr(`RFIA_OFS_FLAGS, 8'h00);
    wr(`RFIA_OFS_SER_CTL1, 8'h00);
    wr(`RFIA_OFS_TIMER_CTL, 8'h00);
  endtask

  // Verdict, reached from the main sequence or the watchdog
  task automatic close_out();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    miscompares++;
    close_out();
  end

  // Main sequence
  initial begin
    miscompares = 0;
    checks_done = 0;
    rst = 1'b1;
    sfr_req = '0;
    src_level = rfia_pkg::rfia_src_s'(8'h00);
    err_level = rfia_pkg::rfia_err_src_s'(2'h0);
    ack_frame_done = 1'b0;
    ack_report_option = 1'b0;
    rx_fill_count = 8'h00;
    rx_fill_threshold = 8'h10;
    // Threshold is strict: equal fill must not flag
    rows = '{'{8'h01, 0, 0, 8'h00, 8'h01}, '{8'h02, 0, 0, 8'h00, 8'h02},
             '{8'h04, 0, 0, 8'h00, 8'h04}, '{8'h08, 0, 0, 8'h00, 8'h08},
             '{8'h10, 0, 0, 8'h00, 8'h10}, '{8'h40, 0, 0, 8'h00, 8'h40},
             '{8'h80, 0, 0, 8'h00, 8'h80}, '{8'h20, 0, 0, 8'h10, 8'h00},
             '{8'h00, 0, 0, 8'h11, 8'h20}, '{8'h00, 1, 1, 8'h00, 8'h40},
             '{8'h00, 1, 0, 8'h00, 8'h00}};
    rst_addrs = '{`RFIA_OFS_FLAGS, `RFIA_OFS_MASK, `RFIA_OFS_IEN_A,
                  `RFIA_OFS_IEN_C, `RFIA_OFS_TIMER_CTL,
                  `RFIA_OFS_SER_CTL1, 8'h00};
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    // Reset state, unmapped address reads zero
    foreach (rst_addrs[i]) rd(rst_addrs[i], 8'h00);
    chk(irq_lines, 16'h0000);
    wr(`RFIA_OFS_MASK, 8'hff);
    rd(`RFIA_OFS_MASK, 8'hff);
    wr(`RFIA_OFS_IEN_C, 8'h01);
    wr(`RFIA_OFS_IEN_A, 8'h01);
    // Each source alone, with every mask bit and main enable set
    foreach (rows[i]) begin
      @(negedge ref_clk);
      ack_frame_done    = rows[i].ack;
      ack_report_option = rows[i].opt;
      rx_fill_count     = rows[i].cnt;
      fire(rows[i].src);
      chk(irq_lines, {3'h0, rows[i].exp != 0, 12'h000});
      rd(`RFIA_OFS_FLAGS, rows[i].exp);
      clear();
    end
    // Masked source still flags but does not request
    wr(`RFIA_OFS_MASK, 8'hf7);
    fire(8'h08);
    chk(radio_event_request, 1'b0);
    rd(`RFIA_OFS_FLAGS, 8'h08);
    rd(`RFIA_OFS_SER_CTL1, 8'h00);
    clear();
    // Main enable off: main flag pends, no request until enabled
    wr(`RFIA_OFS_MASK, 8'hff);
    wr(`RFIA_OFS_IEN_C, 8'h00);
    fire(8'h08);
    chk(radio_event_request, 1'b0);
    rd(`RFIA_OFS_SER_CTL1, 8'h01);
    wr(`RFIA_OFS_IEN_C, 8'h01);
    chk(radio_event_request, 1'b1);
    clear();
    // Held-high level does not set a cleared flag again
    fire(8'h10);
    wr(`RFIA_OFS_FLAGS, 8'h00);
    wr(`RFIA_OFS_SER_CTL1, 8'h00);
    repeat (3) @(negedge ref_clk);
    rd(`RFIA_OFS_FLAGS, 8'h00);
    chk(radio_event_request, 1'b0);
    clear();
    // Leftover flag after service asks for the vector again
    fire(8'h03);
    n_evt = evt_entries;
    wr(`RFIA_OFS_FLAGS, 8'h02);
    wr(`RFIA_OFS_SER_CTL1, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk(radio_event_request, 1'b1);
    chk(evt_entries, n_evt + 8'h01);
    rd(`RFIA_OFS_SER_CTL1, 8'h01);
    rd(`RFIA_OFS_FLAGS, 8'h02);
    wr(`RFIA_OFS_FLAGS, 8'h00);
    wr(`RFIA_OFS_SER_CTL1, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk(radio_event_request, 1'b0);
    // Overflow uses the error vector only
    @(negedge ref_clk);
    err_level = rfia_pkg::rfia_err_src_s'(2'h1);
    @(negedge ref_clk);
    chk(irq_lines, 16'h0001);
    rd(`RFIA_OFS_TIMER_CTL, 8'h01);
    rd(`RFIA_OFS_FLAGS, 8'h00);
    clear();
    chk(radio_error_request, 1'b0);
    // Underflow with error enable off pends until enabled
    wr(`RFIA_OFS_IEN_A, 8'h00);
    @(negedge ref_clk);
    err_level = rfia_pkg::rfia_err_src_s'(2'h2);
    repeat (2) @(negedge ref_clk);
    chk(radio_error_request, 1'b0);
    rd(`RFIA_OFS_TIMER_CTL, 8'h01);
    wr(`RFIA_OFS_IEN_A, 8'h01);
    chk(radio_error_request, 1'b1);
    // Entry is counted one edge after the line rises
    @(negedge ref_clk);
    chk(err_entries, 8'h02);
    clear();
    close_out();
  end
endmodule
